/* hw/rtcpw_params.svh */
/*
 * Constants for the BCD value registers and power window timer.
 * Assumes inclusion by bare name from design files.
 */
`ifndef RTCPW_PARAMS_SVH
`define RTCPW_PARAMS_SVH

// ****************************************
// Register indices on the plain port
// ****************************************
`define RTCPW_ADDR_YEAR 3'h0
`define RTCPW_ADDR_MONTH_DAY_VALUE 3'h1
`define RTCPW_ADDR_ALARM 3'h2
`define RTCPW_ADDR_WINDOW 3'h3
`define RTCPW_ADDR_CTRL 3'h4
`define RTCPW_ADDR_STATUS 3'h5

// ****************************************
// Implemented bit masks
// ****************************************
`define RTCPW_MASK_YEAR 16'h00FF
`define RTCPW_MASK_MONTH_DAY_VALUE 16'h1F3F
`define RTCPW_MASK_ALARM 16'h7F7F
`define RTCPW_MASK_WINDOW 16'hFFFF
`define RTCPW_MASK_CTRL 16'h0003

// ****************************************
// Field positions and codes
// ****************************************
`define RTCPW_CTRL_WREN_BIT 0
`define RTCPW_CTRL_POWER_CONTROL_ENABLE_BIT 1
`define RTCPW_SAMP_ALWAYS 8'hFF
`define RTCPW_STAB_NONE 8'h00
`define RTCPW_ZERO16 16'h0000
`define RTCPW_ZERO8 8'h00
`define RTCPW_ONE8 8'h01

`endif

/* hw/rtcpw_pkg.sv */
/*
 * Types for the BCD value registers and power window timer.
 * Assumes rtcpw_params.svh is available.
 */
package rtcpw_pkg;

   // ****************************************
   // Register bus request
   // ****************************************
   typedef struct packed {
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } rtcpw_req_t;

   // ****************************************
   // Window timer phases
   // ****************************************
   typedef enum logic [1:0] {
      RTCPW_IDLE = 2'b00,
      RTCPW_STAB = 2'b01,
      RTCPW_SAMP = 2'b10
   } rtcpw_phase_t;

endpackage : rtcpw_pkg

/* hw/rtcpw_window.sv */
/*
 * Power control window timer: stability window then sample window.
 * Assumes a one-cycle pulse per power-control clock period and
 * a synchronous alarm event pulse.
 */
`timescale 1ns/1ps
`default_nettype none

`include "rtcpw_params.svh"

module rtcpw_window
   import rtcpw_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Controls
   input wire logic tick_i,
   input wire logic alarm_i,
   input wire logic enable_i,
   input wire logic [7:0] stab_len_i,
   input wire logic [7:0] samp_len_i,
   // Result
   output logic sample_o,
   output logic busy_o
);

   typedef struct packed {
      rtcpw_phase_t phase;
      logic [7:0] count;
      logic sample;
   } rtcpw_win_state_t;

   rtcpw_win_state_t st_reg;
   rtcpw_win_state_t st_next;
   logic always_on;

   assign always_on = (samp_len_i == `RTCPW_SAMP_ALWAYS);

   // Next state of the window sequencer
   always_comb
   begin
      st_next = st_reg;
      if (!enable_i)
      begin
         st_next.phase = RTCPW_IDLE;
         st_next.count = `RTCPW_ZERO8;
      end
      else if (alarm_i)
      begin
         if (stab_len_i == `RTCPW_STAB_NONE)
         begin
            st_next.phase = RTCPW_SAMP;
            st_next.count = samp_len_i;
         end
         else
         begin
            st_next.phase = RTCPW_STAB;
            st_next.count = stab_len_i;
         end
      end
      else if (tick_i)
      begin
         case (st_reg.phase)
            RTCPW_STAB:
            begin
               if (st_reg.count <= `RTCPW_ONE8)
               begin
                  st_next.phase = RTCPW_SAMP;
                  st_next.count = samp_len_i;
               end
               else
               begin
                  st_next.count = st_reg.count - `RTCPW_ONE8;
               end
            end
            RTCPW_SAMP:
            begin
               if (!always_on && st_reg.count <= `RTCPW_ONE8)
               begin
                  st_next.phase = RTCPW_IDLE;
                  st_next.count = `RTCPW_ZERO8;
               end
               else if (!always_on)
               begin
                  st_next.count = st_reg.count - `RTCPW_ONE8;
               end
            end
            default:
            begin
               st_next.phase = RTCPW_IDLE;
            end
         endcase
      end
      // A zero-length sample window never asserts the output
      if (st_next.phase == RTCPW_SAMP && st_next.count == `RTCPW_ZERO8 && !always_on)
      begin
         st_next.phase = RTCPW_IDLE;
      end
      st_next.sample = always_on || (st_next.phase == RTCPW_SAMP);
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_reg <= '{phase: RTCPW_IDLE, count: `RTCPW_ZERO8, sample: 1'b0};
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign sample_o = st_reg.sample;
   assign busy_o = (st_reg.phase != RTCPW_IDLE);

endmodule : rtcpw_window

`default_nettype wire

/* hw/rtcpw_top.sv */
/*
 * BCD year, month/day and alarm value registers with a power
 * control window timer, reached over a plain register port.
 * Assumes the alarm event and power-control clock arrive from
 * outside this clock domain and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

`include "rtcpw_params.svh"

module rtcpw_top
   import rtcpw_pkg::*;
(
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   // Register port
   input wire logic [2:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [15:0] RDATA_O,
   // Unit links
   input wire logic ALARM_EVENT_I,
   input wire logic PWC_CLK_I,
   // Power control pin
   output logic PWC_OUT_O
);

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [15:0] year;
      logic [15:0] month_day_value;
      logic [15:0] alarm;
      logic [15:0] window;
      logic [15:0] ctrl;
      logic [15:0] rdata;
      logic [1:0] alarm_sync;
      logic alarm_prev;
      logic [1:0] pclk_sync;
      logic pclk_prev;
   } rtcpw_state_t;

   rtcpw_state_t st_reg;
   rtcpw_state_t st_next;
   rtcpw_req_t req;
   logic wren;
   logic alarm_pulse;
   logic tick;
   logic sample;
   logic busy;

   assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
   assign wren = st_reg.ctrl[`RTCPW_CTRL_WREN_BIT];
   // Edges taken from second synchroniser stage only
   assign alarm_pulse = st_reg.alarm_sync[1] && !st_reg.alarm_prev;
   assign tick = st_reg.pclk_sync[1] && !st_reg.pclk_prev;

   // ****************************************
   // Window timer
   // ****************************************
   rtcpw_window u_window (
      .clk_i(REF_CLK_I),
      .rst_i(RESET_I),
      .tick_i(tick),
      .alarm_i(alarm_pulse),
      .enable_i(st_reg.ctrl[`RTCPW_CTRL_POWER_CONTROL_ENABLE_BIT]),
      .stab_len_i(st_reg.window[15:8]),
      .samp_len_i(st_reg.window[7:0]),
      .sample_o(sample),
      .busy_o(busy)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      st_next = st_reg;
      // Synchronisers and edge history
      st_next.alarm_sync = {st_reg.alarm_sync[0], ALARM_EVENT_I};
      st_next.alarm_prev = st_reg.alarm_sync[1];
      st_next.pclk_sync = {st_reg.pclk_sync[0], PWC_CLK_I};
      st_next.pclk_prev = st_reg.pclk_sync[1];
      // Register writes
      if (req.wr)
      begin
         case (req.addr)
            `RTCPW_ADDR_YEAR:
            begin
               if (wren)
               begin
                  st_next.year = req.wdata & `RTCPW_MASK_YEAR;
               end
            end
            `RTCPW_ADDR_MONTH_DAY_VALUE:
            begin
               if (wren)
               begin
                  st_next.month_day_value = req.wdata & `RTCPW_MASK_MONTH_DAY_VALUE;
               end
            end
            `RTCPW_ADDR_ALARM:
            begin
               st_next.alarm = req.wdata & `RTCPW_MASK_ALARM;
            end
            `RTCPW_ADDR_WINDOW:
            begin
               if (wren)
               begin
                  st_next.window = req.wdata & `RTCPW_MASK_WINDOW;
               end
            end
            `RTCPW_ADDR_CTRL:
            begin
               st_next.ctrl = req.wdata & `RTCPW_MASK_CTRL;
            end
            default:
            begin
               st_next.ctrl = st_reg.ctrl;
            end
         endcase
      end
      // Register reads, data in the following cycle
      st_next.rdata = `RTCPW_ZERO16;
      if (req.rd)
      begin
         case (req.addr)
            `RTCPW_ADDR_YEAR: st_next.rdata = st_reg.year & `RTCPW_MASK_YEAR;
            `RTCPW_ADDR_MONTH_DAY_VALUE: st_next.rdata = st_reg.month_day_value & `RTCPW_MASK_MONTH_DAY_VALUE;
            `RTCPW_ADDR_ALARM: st_next.rdata = st_reg.alarm & `RTCPW_MASK_ALARM;
            `RTCPW_ADDR_WINDOW: st_next.rdata = st_reg.window;
            `RTCPW_ADDR_CTRL: st_next.rdata = st_reg.ctrl;
            `RTCPW_ADDR_STATUS: st_next.rdata = {14'h0000, busy, sample};
            default: st_next.rdata = `RTCPW_ZERO16;
         endcase
      end
   end

   // State register
   always_ff @(posedge REF_CLK_I or posedge RESET_I)
   begin
      if (RESET_I)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // Outputs from flip-flops
   assign RDATA_O = st_reg.rdata;
   assign PWC_OUT_O = sample;

endmodule : rtcpw_top

`default_nettype wire

/* verif/rtcpw_monitor.sv */
/* Checker on the rtcpw_top ports.
   Assumes it is bound to every rtcpw_top instance. */
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module rtcpw_monitor (
   // Watched ports
   input wire logic REF_CLK_I,
   input wire logic RESET_I,
   input wire logic [2:0] ADDR_I,
   input wire logic [15:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   input wire logic [15:0] RDATA_O,
   input wire logic PWC_OUT_O
);
   logic wen_reg;
   logic pen_reg;
   logic ff_reg;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);
   // Shadow of enable bits and the always-on sample code
   always_ff @(posedge REF_CLK_I or posedge RESET_I)
      if (RESET_I)
         {wen_reg, pen_reg, ff_reg} <= 3'h0;
      else if (WR_I && ADDR_I == 3'h4)
         {pen_reg, wen_reg} <= WDATA_I[1:0];
      else if (WR_I && ADDR_I == 3'h3 && wen_reg)
         ff_reg <= (WDATA_I[7:0] == 8'hFF);
   year_write_a: assert property (
      WR_I && ADDR_I == 3'h0 && wen_reg ##1 RD_I && ADDR_I == 3'h0
      |=> RDATA_O == ($past(WDATA_I, 2) & 16'h00FF)) else $error("year readback wrong");
   month_day_value_write_a: assert property (
      WR_I && ADDR_I == 3'h1 && wen_reg ##1 RD_I && ADDR_I == 3'h1
      |=> RDATA_O == ($past(WDATA_I, 2) & 16'h1F3F)) else $error("month day readback wrong");
   alarm_write_a: assert property (
      WR_I && ADDR_I == 3'h2 ##1 RD_I && ADDR_I == 3'h2
      |=> RDATA_O == ($past(WDATA_I, 2) & 16'h7F7F)) else $error("alarm readback wrong");
   window_write_a: assert property (
      WR_I && ADDR_I == 3'h3 && wen_reg ##1 RD_I && ADDR_I == 3'h3
      |=> RDATA_O == $past(WDATA_I, 2)) else $error("window readback wrong");
   year_zero_a: assert property (
      RD_I && ADDR_I == 3'h0 |=> RDATA_O[15:8] == 8'h00) else $error("year upper bits set");
   month_day_value_zero_a: assert property (
      RD_I && ADDR_I == 3'h1 |=> RDATA_O[15:13] == 3'h0 && RDATA_O[7:6] == 2'h0)
      else $error("month day spare bits set");
   alarm_zero_a: assert property (
      RD_I && ADDR_I == 3'h2 |=> !RDATA_O[15] && !RDATA_O[7]) else $error("alarm spare bits set");
   always_on_a: assert property (
      ff_reg && $past(ff_reg, 8) |-> PWC_OUT_O) else $error("always-on output low");
   idle_low_a: assert property (
      !pen_reg && !ff_reg && $past(!pen_reg && !ff_reg, 8) |-> !PWC_OUT_O)
      else $error("output high while disabled");
endmodule : rtcpw_monitor
bind rtcpw_top rtcpw_monitor u_mon (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .PWC_OUT_O(PWC_OUT_O));
`default_nettype wire

/* verif/tb.sv */
/* Self-checking bench for rtcpw_top.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic alarm = 1'b0;
   logic pwc_clk = 1'b0;
   logic rd_d = 1'b0;
   logic [15:0] rdata;
   logic pwc_out;
   logic [31:0] seed = 32'h00006B18;
   logic [15:0] v;
   logic [15:0] msk [4] = '{16'h00FF, 16'h1F3F, 16'h7F7F, 16'hFFFF};
   logic [15:0] expq [$];
   int mismatches = 0;
   int n_compared = 0;
   rtcpw_top uut (.REF_CLK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
      .RD_I(rd), .RDATA_O(rdata), .ALARM_EVENT_I(alarm), .PWC_CLK_I(pwc_clk), .PWC_OUT_O(pwc_out));
   // Clock
   always #5 clk = ~clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One bus cycle; a read notes its expected data
   task automatic op(input logic w, input logic [2:0] a, input logic [15:0] d);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      if (!w)
         expq.push_back(d);
      @(posedge clk);
   endtask : op
   task automatic idle();
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask : idle
   task automatic tick();
      pwc_clk <= 1'b1;
      repeat (10) @(posedge clk);
      pwc_clk <= 1'b0;
   endtask : tick
   // Alarm then step the window one power-control period at a time
   task automatic win(input logic [7:0] st, input logic [7:0] sa, input logic [1:0] ct);
      logic ex;
      logic bz;
      op(1'b1, 3'h3, {st, sa});
      op(1'b1, 3'h4, {14'h0, ct});
      op(1'b0, 3'h4, {14'h0, ct});
      idle();
      alarm <= 1'b1;
      for (int k = 0; k <= st + sa; k++)
      begin
         if (k > 0)
            tick();
         repeat (10) @(posedge clk);
         ex = (sa == 8'hFF) || (ct[1] && k >= st && k < st + sa);
         bz = ct[1] && (k < st + sa);
         chk("PWC_OUT_O", {15'h0, pwc_out}, {15'h0, ex});
         // Status holds the window busy flag above the sample flag
         op(1'b0, 3'h5, {14'h0, bz, ex});
         idle();
      end
      alarm <= 1'b0;
      repeat (10) @(posedge clk);
      $display("window %h %h %h done", st, sa, ct);
   endtask : win
   task automatic tally_and_finish();
      $display("compared %0d mismatched %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   // Read data watcher
   always @(posedge clk)
      rd_d <= rd;
   always @(negedge clk)
      if (rd_d && expq.size() > 0)
         chk("RDATA_O", rdata, expq.pop_front());
   // Hang guard
   initial
   begin
      repeat (100000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a < 4; a++)
      begin
         op(1'b1, a[2:0], 16'hFFFF);
         op(1'b0, a[2:0], (a == 2) ? 16'h7F7F : 16'h0000);
      end
      $display("gated writes done");
      op(1'b1, 3'h4, 16'h0001);
      for (int i = 0; i < 12; i++)
      begin
         seed = xs(seed);
         v = (i == 0) ? 16'hFFFF : seed[15:0];
         for (int a = 0; a < 4; a++)
         begin
            op(1'b1, a[2:0], v);
            op(1'b0, a[2:0], v & msk[a]);
         end
      end
      idle();
      $display("readback done");
      win(8'h02, 8'h03, 2'h3);
      win(8'h00, 8'h02, 2'h3);
      win(8'h01, 8'h00, 2'h3);
      win(8'h02, 8'h03, 2'h1);
      win(8'h00, 8'hFF, 2'h1);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
